/* alfb_pkg.sv */
`default_nettype none
package alfb_pkg;
  // Register offsets
  localparam logic [7:0] ALERT_EN_OFFS  = 8'h2A;
  localparam logic [7:0] FULLNESS_OFFS  = 8'h29;
  localparam logic [7:0] OVERCURRENT_THRESHOLD_OFFS  = 8'h30;
  localparam logic [7:0] OVERCURRENT_THRESHOLD_LAST  = 8'h33;
  // Alert enable bit positions
  localparam int OP_EN_MSB    = 7;
  localparam int OP_EN_LSB    = 4;
  localparam int ACC_FLAG_BIT = 3;
  localparam int CNT_FLAG_BIT = 2;
  localparam int CC_PULSE_BIT = 1;
  // Fullness field positions
  localparam int THR_CH1_LSB  = 14;
  localparam int THR_CNT_LSB  = 6;
  // Fullness level codes
  localparam logic [1:0] LVL_FULL  = 2'h0;
  localparam logic [1:0] LVL_15_16 = 2'h1;
  localparam logic [1:0] LVL_7_8   = 2'h2;
  localparam logic [1:0] LVL_3_4   = 2'h3;
  // Reset values
  localparam logic [7:0]  ALERT_EN_RST = 8'h00;
  localparam logic [9:0]  FULLNESS_RST = 10'h155;
  localparam logic [15:0] OVERCURRENT_THRESHOLD_RST = 16'h0000;
  // Accumulator and sample counter widths
  localparam int ACC_W = 32;
  localparam int CNT_W = 24;
  // Conversion-complete pulse timing
  localparam int CLK_PS      = 4000;
  localparam int PULSE_US    = 5;
  localparam int PULSE_CYC   = (PULSE_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int PCNT_W      = 11;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } alfb_req_t;

  typedef struct packed {
    logic [3:0][ACC_W-1:0] acc_val;
    logic [3:0]            accumulator_fullness_flag;
    logic [CNT_W-1:0]      cnt_val;
    logic                  cnt_ovf;
    logic [3:0][15:0]      isense;
  } alfb_meas_t;

  typedef enum logic {PS_IDLE, PS_PULSE} alfb_pstate_t;
endpackage
`default_nettype wire

/* alfb_bank.sv */
// Operation
// RULE1 - Bits 5,4 enable channel 3,4 overpower
// RULE2 - Bit 3 flags accumulator fullness
// RULE3 - Bit 2 flags sample counter fullness
// RULE4 - Bit 1 gives 5 us conversion pulse
// RULE5 - Pulse reaches pin only in alert mode
// RULE6 - Alert mode ignores pin slow request input
// RULE7 - Levels: full, 15/16, 7/8, 3/4
// RULE8 - Channel fields at bits 15-8
// RULE9 - Counter field bits 7-6, 5-0 zero
// RULE10 - Compare values against chosen fraction
// RULE11 - Host disables alerts before rewriting limits
// RULE12 - Signed 16-bit overcurrent limits, reset zero
// RULE13 - Limits at 30h through 33h
// RULE14 - Bits 7,6 enable channel 1,2 overpower
// RULE15 - Overcurrent when current exceeds limit signed
// RULE16 - Fullness flags sticky until accumulators cleared
`timescale 1ns/1ps
`default_nettype none
module alfb_bank (
  input  wire logic              clk,          // 250 MHz clock
  input  wire logic              rst_n,        // Async reset, active low
  input  wire alfb_pkg::alfb_req_t  req,       // Register access request
  output logic [15:0]            rdata,        // Read data, next cycle
  input  wire alfb_pkg::alfb_meas_t meas,      // Measurement results
  input  wire logic              acc_clear,    // Accumulators cleared
  input  wire logic [3:0]        op_exceed,    // Raw overpower events
  input  wire logic              conv_done,    // End of conversion pulse
  input  wire logic              pin_is_alert, // Second pin in alert mode
  input  wire logic              pin_in,       // Second pin input level
  output logic                   second_alert_pin, // Second pin drive
  output logic                   second_alert_oe,  // Second pin enable
  output logic                   slow_req,     // Slow sampling request
  output logic [3:0]             oc_event,     // Overcurrent per channel
  output logic                   alert         // Combined alert
);
  import alfb_pkg::*;

  logic [7:0]         alert_en_r, alert_en_nxt;
  logic [9:0]         fullness_r, fullness_nxt;
  logic [3:0][15:0]   oc_lim_r, oc_lim_nxt;
  logic               acc_flag_r, acc_flag_nxt;
  logic               cnt_flag_r, cnt_flag_nxt;
  logic [15:0]        rdata_nxt;
  alfb_pstate_t       pst_r, pst_nxt;
  logic [PCNT_W-1:0]  pcnt_r, pcnt_nxt;
  logic               pin_nxt, oe_nxt, slow_nxt, alert_nxt;
  logic [3:0]         oc_nxt, acc_hit;
  logic               cnt_hit;
  logic [3:0]         op_en_ch;
  logic [1:0]         oc_idx;

  // Fraction-of-full test on top bits
  function automatic logic level_hit(input logic [1:0] lvl,
                                     input logic [3:0] top,
                                     input logic       full);
    logic h;
    h = 1'b0;
    case (lvl)
      LVL_FULL:  h = full;                  // [RULE7]
      LVL_15_16: h = full | (&top);         // [RULE7]
      LVL_7_8:   h = full | (&top[3:1]);    // [RULE7]
      LVL_3_4:   h = full | (&top[3:2]);    // [RULE7]
      default:   h = full;
    endcase
    return h;
  endfunction

  // Per-channel fullness and overcurrent compare
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      assign acc_hit[g] = level_hit(
        fullness_r[THR_CH1_LSB-THR_CNT_LSB-2*g +: 2],       // [RULE8]
        meas.acc_val[g][ACC_W-1 -: 4],
        meas.accumulator_fullness_flag[g] | (&meas.acc_val[g]));              // [RULE10]
      assign oc_nxt[g] = $signed(meas.isense[g])
                         > $signed(oc_lim_r[g]);            // [RULE15]
      // Channel 1 enable sits in the top bit, channel 4 in the lowest
      assign op_en_ch[g] = alert_en_r[OP_EN_MSB - g];      // [RULE1] [RULE14]
    end
  endgenerate
  assign cnt_hit = level_hit(fullness_r[1:0], meas.cnt_val[CNT_W-1 -: 4],
                             meas.cnt_ovf | (&meas.cnt_val)); // [RULE10]
  assign oc_idx = req.addr[1:0];

  // Register writes, flags and read mux
  always_comb begin
    alert_en_nxt = alert_en_r;
    fullness_nxt = fullness_r;
    oc_lim_nxt   = oc_lim_r;
    rdata_nxt    = 16'h0000;
    if (req.wr) begin
      if (req.addr == ALERT_EN_OFFS) begin
        alert_en_nxt[OP_EN_MSB:OP_EN_LSB] =
          req.wdata[OP_EN_MSB:OP_EN_LSB];                   // [RULE1] [RULE14]
        alert_en_nxt[CC_PULSE_BIT] = req.wdata[CC_PULSE_BIT];
      end else if (req.addr == FULLNESS_OFFS) begin
        fullness_nxt = req.wdata[15:THR_CNT_LSB];           // [RULE8] [RULE9]
      end else if (req.addr >= OVERCURRENT_THRESHOLD_OFFS &&
                   req.addr <= OVERCURRENT_THRESHOLD_LAST) begin
        oc_lim_nxt[oc_idx] = req.wdata;                     // [RULE12] [RULE13]
      end
    end
    if (req.rd) begin
      if (req.addr == ALERT_EN_OFFS) begin
        rdata_nxt = {8'h00, alert_en_r[7:4], acc_flag_r, cnt_flag_r,
                     alert_en_r[CC_PULSE_BIT], 1'b0};
      end else if (req.addr == FULLNESS_OFFS) begin
        rdata_nxt = {fullness_r, 6'h00};                    // [RULE9]
      end else if (req.addr >= OVERCURRENT_THRESHOLD_OFFS &&
                   req.addr <= OVERCURRENT_THRESHOLD_LAST) begin
        rdata_nxt = oc_lim_r[oc_idx];                       // [RULE13]
      end
    end
    // Sticky flags, a new hit wins over a clear
    acc_flag_nxt = (acc_flag_r & ~acc_clear) | (|acc_hit);  // [RULE2] [RULE16]
    cnt_flag_nxt = (cnt_flag_r & ~acc_clear) | cnt_hit;     // [RULE3] [RULE16]
    alert_nxt = acc_flag_r | cnt_flag_r |
                (|(op_exceed & op_en_ch));                  // [RULE16]
  end

  // Conversion-complete pulse sequencer
  always_comb begin
    pst_nxt  = pst_r;
    pcnt_nxt = pcnt_r;
    case (pst_r)
      PS_IDLE: begin
        if (conv_done && alert_en_r[CC_PULSE_BIT]) begin    // [RULE4]
          pst_nxt  = PS_PULSE;
          pcnt_nxt = '0;
        end
      end
      PS_PULSE: begin
        if (pcnt_r == PCNT_W'(PULSE_CYC - 1)) begin         // [RULE4]
          pst_nxt = PS_IDLE;
        end else begin
          pcnt_nxt = pcnt_r + 1'b1;
        end
      end
      default: pst_nxt = PS_IDLE;
    endcase
    pin_nxt  = (pst_nxt == PS_PULSE) && pin_is_alert;       // [RULE5]
    oe_nxt   = pin_is_alert;                                // [RULE5]
    slow_nxt = pin_in && !pin_is_alert;                     // [RULE6]
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_en_r       <= ALERT_EN_RST;
      fullness_r       <= FULLNESS_RST;
      oc_lim_r         <= {4{OVERCURRENT_THRESHOLD_RST}};
      acc_flag_r       <= 1'b0;
      cnt_flag_r       <= 1'b0;
      rdata            <= 16'h0000;
      pst_r            <= PS_IDLE;
      pcnt_r           <= '0;
      second_alert_pin <= 1'b0;
      second_alert_oe  <= 1'b0;
      slow_req         <= 1'b0;
      oc_event         <= 4'h0;
      alert            <= 1'b0;
    end else begin
      alert_en_r       <= alert_en_nxt;
      fullness_r       <= fullness_nxt;
      oc_lim_r         <= oc_lim_nxt;
      acc_flag_r       <= acc_flag_nxt;
      cnt_flag_r       <= cnt_flag_nxt;
      rdata            <= rdata_nxt;
      pst_r            <= pst_nxt;
      pcnt_r           <= pcnt_nxt;
      second_alert_pin <= pin_nxt;
      second_alert_oe  <= oe_nxt;
      slow_req         <= slow_nxt;
      oc_event         <= oc_nxt;
      alert            <= alert_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  op_en_write_a: assert property ( // [RULE1]
    req.wr && req.addr == ALERT_EN_OFFS |=>
    alert_en_r[5:4] == $past(req.wdata[5:4]))
    else $error("overpower enable 3/4 not stored");
  op_en12_a: assert property ( // [RULE14]
    req.wr && req.addr == ALERT_EN_OFFS |=>
    alert_en_r[7:6] == $past(req.wdata[7:6]))
    else $error("overpower enable 1/2 not stored");
  op_gate_a: assert property ( // [RULE14]
    op_exceed[0] && alert_en_r[OP_EN_MSB] |=> alert)
    else $error("channel 1 overpower alert missed");
  acc_flag_a: assert property (|acc_hit |=> acc_flag_r)  // [RULE2]
    else $error("accumulator flag missed");
  cnt_flag_a: assert property (cnt_hit |=> cnt_flag_r)  // [RULE3]
    else $error("counter flag missed");
  flag_hold_a: assert property ( // [RULE16]
    acc_flag_r && !acc_clear |=> acc_flag_r)
    else $error("fullness flag dropped");
  pulse_start_a: assert property ( // [RULE4]
    pst_r == PS_IDLE && conv_done && alert_en_r[1] && pin_is_alert |=>
    second_alert_pin [*8])
    else $error("conversion pulse not driven");
  pulse_end_a: assert property ( // [RULE4]
    pst_r == PS_PULSE && pcnt_r == PCNT_W'(PULSE_CYC - 1) |=>
    pst_r == PS_IDLE)
    else $error("conversion pulse length wrong");
  pin_gate_a: assert property (!pin_is_alert |=> !second_alert_pin) // [RULE5]
    else $error("pulse drove pin outside alert mode");
  slow_ign_a: assert property (pin_is_alert |=> !slow_req)  // [RULE6]
    else $error("slow request taken in alert mode");
  full_read_a: assert property ( // [RULE9]
    req.rd && req.addr == FULLNESS_OFFS |=>
    rdata[5:0] == 6'h00 && rdata[15:6] == $past(fullness_r))
    else $error("fullness read wrong");
  oc_cmp_a: assert property ( // [RULE15]
    $signed(meas.isense[0]) > $signed(oc_lim_r[0]) |=> oc_event[0])
    else $error("overcurrent channel 1 missed");

  pulse_c: cover property (pst_r == PS_PULSE && pcnt_r ==
    PCNT_W'(PULSE_CYC - 1));
  acc_c: cover property (acc_flag_r && acc_clear);
  oc_c: cover property (oc_event == 4'hF);
endmodule
`default_nettype wire

/* alfb_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module alert_limit_fullness_bank_tb_top;
  import alfb_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n;
  alfb_req_t   req;
  logic [15:0] rdata;
  alfb_meas_t  meas;
  logic        acc_clear, conv_done, pin_is_alert, pin_in;
  logic [3:0]  op_exceed, oc_event;
  logic        second_alert_pin, second_alert_oe, slow_req, alert;
  int          err_count = 0;
  int          checks_done = 0;
  logic [15:0] oc_lim [4];
  logic [15:0] d;
  int          i, k, lv, s;

  alfb_bank i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .meas(meas), .acc_clear(acc_clear), .op_exceed(op_exceed),
    .conv_done(conv_done), .pin_is_alert(pin_is_alert), .pin_in(pin_in),
    .second_alert_pin(second_alert_pin), .second_alert_oe(second_alert_oe),
    .slow_req(slow_req), .oc_event(oc_event), .alert(alert));

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  task automatic test_done();
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Advance n edges, then settle 1 ns past the edge
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Write strobe for one edge, then one idle edge
  task automatic wr_reg(logic [7:0] a, logic [15:0] v);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask

  // Read, capture data the cycle after the strobe edge, compare
  task automatic chk_reg(logic [7:0] a, logic [15:0] e);
    logic [15:0] v;
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    req.rd = 1'b0;
    v = rdata;
    `CHK(v, e)
    step(1);
  endtask

  // Value with the top bits set that a fullness level trips at
  function automatic logic [31:0] hitv(int w, int lvl);
    logic [31:0] m;
    m = (w == 32) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
    if (lvl == 0) return m;
    return m & ~(m >> (lvl == 1 ? 4 : (lvl == 2 ? 3 : 2)));
  endfunction

  // Address of one overcurrent limit register
  function automatic logic [7:0] oc_addr(int n);
    return 8'(OVERCURRENT_THRESHOLD_OFFS + n);
  endfunction

  // Expected overcurrent flag from a signed compare
  function automatic logic oc_exp(int n);
    return $signed(meas.isense[n]) > $signed(oc_lim[n]);
  endfunction

  // Load one accumulator or the counter with a value
  task automatic set_val(int sc, int c, logic [31:0] v);
    if (sc == 1) meas.cnt_val = v[CNT_W-1:0];
    else meas.acc_val[c] = v;
  endtask

  // Conversion pulse width, pin masking and slow request gating
  task automatic pulse_case(logic en, logic pa, int e);
    int hi;
    wr_reg(ALERT_EN_OFFS, {14'h0000, en, 1'b0});
    pin_is_alert = pa;
    pin_in = 1'($urandom);
    step(1);
    `CHK(slow_req, pin_in & ~pa)
    `CHK(second_alert_oe, pa)
    conv_done = 1'b1;
    step(1);
    conv_done = 1'b0;
    hi = 0;
    repeat (1300) begin
      if (second_alert_pin === 1'b1) hi++;
      step(1);
    end
    `CHK(hi, e)
  endtask

  // Main sequence
  initial begin
    req = '0;
    meas = '0;
    {acc_clear, conv_done, pin_is_alert, pin_in, op_exceed} = '0;
    rst_n = 1'b0;
    void'($urandom(32'hEB24C15C));
    step(20);
    rst_n = 1'b1;
    chk_reg(FULLNESS_OFFS, 16'h5540);
    chk_reg(ALERT_EN_OFFS, 16'h0000);
    for (i = 0; i < 4; i++) chk_reg(oc_addr(i), 16'h0000);
    chk_reg(8'h2B, 16'h0000);
    for (i = 0; i < 4; i++) oc_lim[i] = 16'h0000;
    repeat (20) begin
      wr_reg(ALERT_EN_OFFS, 16'h0000);
      d = 16'($urandom);
      wr_reg(FULLNESS_OFFS, d);
      chk_reg(FULLNESS_OFFS, d & 16'hFFC0);
      i = $urandom_range(3);
      d = 16'($urandom);
      wr_reg(oc_addr(i), d);
      oc_lim[i] = d;
      wr_reg(8'h34, ~d);
      chk_reg(oc_addr(i), d);
      chk_reg(8'h34, 16'h0000);
      wr_reg(ALERT_EN_OFFS, ~d);
      chk_reg(ALERT_EN_OFFS, ~d & 16'h00F2);
    end
    // Signed limit compare, equal and just-above corners first
    for (k = 0; k < 30; k++) begin
      for (i = 0; i < 4; i++) meas.isense[i] = 16'($urandom);
      if (k == 0) meas.isense = {oc_lim[3] + 16'h1, oc_lim[2],
                                 16'h8000, 16'h7FFF};
      step(1);
      for (i = 0; i < 4; i++) `CHK(oc_event[i], oc_exp(i))
    end
    // Overpower gating for every enable pattern
    for (k = 0; k < 16; k++) begin
      wr_reg(ALERT_EN_OFFS, {8'h00, k[3:0], 4'h0});
      op_exceed = 4'($urandom);
      step(1);
      `CHK(alert, |(op_exceed & {k[0], k[1], k[2], k[3]}))
      op_exceed = 4'h0;
    end
    wr_reg(ALERT_EN_OFFS, 16'h0000);
    // Every level, just below and at the trip point, then sticky clear
    for (s = 0; s < 2; s++)
      for (lv = 0; lv < 4; lv++) begin
        i = $urandom_range(3);
        d = (s == 1) ? 16'(lv << 6) : 16'(lv << (14 - 2 * i));
        wr_reg(FULLNESS_OFFS, d);
        set_val(s, i, hitv(s == 1 ? CNT_W : ACC_W, lv) - 32'h1);
        step(2);
        chk_reg(ALERT_EN_OFFS, 16'h0000);
        set_val(s, i, hitv(s == 1 ? CNT_W : ACC_W, lv));
        step(2);
        set_val(s, i, 32'h0);
        step(2);
        `CHK(alert, 1'b1)
        chk_reg(ALERT_EN_OFFS, 16'h0008 >> s);
        acc_clear = 1'b1;
        step(1);
        acc_clear = 1'b0;
        step(1);
        chk_reg(ALERT_EN_OFFS, 16'h0000);
      end
    meas.accumulator_fullness_flag = 4'h4;
    meas.cnt_ovf = 1'b1;
    step(2);
    chk_reg(ALERT_EN_OFFS, 16'h000C);
    meas = '0;
    acc_clear = 1'b1;
    step(1);
    acc_clear = 1'b0;
    pulse_case(1'b1, 1'b1, 1250);
    pulse_case(1'b1, 1'b0, 0);
    pulse_case(1'b0, 1'b1, 0);
    test_done();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
